//--- hdl/bcc_pkg.sv
`default_nettype none

package bcc_pkg;

    // =========================================================
    // register map
    localparam logic [7:0] BCC_CTRL_OFS = 8'h00;
    localparam logic [7:0] BCC_STAT_OFS = 8'h04;

    // =========================================================
    // control register layout
    localparam int BCC_BIT_REQ_ACCEPT = 19;
    localparam int BCC_BIT_MUX_SEL = 17;
    localparam int BCC_BIT_DMA_PRIO = 16;
    localparam int BCC_BIT_ADDR_FLOAT = 15;
    localparam int BCC_BIT_STRB_FLOAT = 14;
    localparam int BCC_A0_BURST_LSB = 11;
    localparam int BCC_A5_BURST_LSB = 8;
    localparam int BCC_A6_BURST_LSB = 5;
    localparam int BCC_BURST_W = 3;
    localparam logic [31:0] BCC_CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] BCC_CTRL_WMASK = 32'h000B_FFE0;

    // =========================================================
    // status register layout
    localparam int BCC_STAT_OWNER_LSB = 0;
    localparam int BCC_STAT_SLAVE = 4;
    localparam int BCC_STAT_A0MUX = 5;
    localparam int BCC_STAT_STRAP_DONE = 6;

    // =========================================================
    // burst codes and access counts
    localparam logic [2:0] BCC_BURST_SRAM = 3'h0;
    localparam logic [2:0] BCC_BURST_4 = 3'h1;
    localparam logic [2:0] BCC_BURST_8 = 3'h2;
    localparam logic [2:0] BCC_BURST_16 = 3'h3;
    localparam logic [2:0] BCC_BURST_32 = 3'h4;
    localparam logic [5:0] BCC_LEN_NONE = 6'h00;
    localparam logic [5:0] BCC_LEN_4 = 6'h04;
    localparam logic [5:0] BCC_LEN_8 = 6'h08;
    localparam logic [5:0] BCC_LEN_16 = 6'h10;
    localparam logic [5:0] BCC_LEN_32 = 6'h20;

    // =========================================================
    // strap capture wait after reset release
    localparam logic [1:0] BCC_STRAP_WAIT = 2'h2;

    // =========================================================
    // bus owner
    typedef enum logic [2:0] {
        OWN_NONE,
        OWN_EXT,
        OWN_PCI,
        OWN_REFRESH,
        OWN_DMA,
        OWN_CPU
    } bcc_owner_type;

endpackage : bcc_pkg

`default_nettype wire

//--- hdl/bcc_bus_control.sv
// Contract
// - slave start: PCI controller requests always accepted
// - slave start: request enable field disregarded
// - bit 19 gates external and PCI requests
// - bit 17 selects multiplexed bus, areas 1-6
// - multiplexed select resets to zero
// - priority off: release, refresh, DMA, CPU
// - priority on: DMA burst blocks release, refresh
// - DMA burst priority resets off
// - bit 15 floats or drives address group; the code uses bit 15 only in standby and floats the group on every release
// - bit 14 floats or drives strobe group
// - area 0 burst code selects SRAM/burst length
// - area 0 multiplexed: ignore its burst field
// - area 5 burst field, same encoding
// - area 5 multiplexed: ignore its burst field
// - area 6 burst field, ignored when multiplexed
// - area 6 burst encoding as area 0
//
// Local design decisions: the placing of the registers and strobed register access.
`default_nettype none

module bcc_bus_control
    import bcc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic slave_mode_pin,
    input wire logic area0_mux_pin,
    input wire logic pc_card_sel,
    input wire logic ext_bus_req_pin,
    input wire logic pci_bus_req,
    input wire logic refresh_req,
    input wire logic dma_req,
    input wire logic dma_burst_active,
    input wire logic cpu_req,
    input wire logic standby,
    input wire logic bus_access_start,
    output logic ext_bus_grant,
    output logic pci_bus_grant,
    output logic refresh_grant,
    output logic dma_grant,
    output logic cpu_grant,
    output logic addr_group_oe_n,
    output logic strobe_group_oe_n,
    output logic [6:0] area_mux_sel,
    output logic [5:0] area_zero_burst_len,
    output logic [5:0] area_five_burst_len,
    output logic [5:0] area_six_burst_len,
    output logic slave_mode
);

    // =========================================================
    // elaboration checks
    generate
        if (ADDR_W < 3 || ADDR_W > 8) begin : g_bad_addr_w
            $error("bcc_bus_control: ADDR_W must lie in 3..8");
        end
    endgenerate

    localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'(BCC_CTRL_OFS);
    localparam logic [ADDR_W-1:0] STAT_ADDR = ADDR_W'(BCC_STAT_OFS);

    // =========================================================
    // state
    typedef struct packed {
        logic ext_req_s1;
        logic ext_req_s2;
        logic slave_s1;
        logic slave_s2;
        logic a0mux_s1;
        logic a0mux_s2;
        logic [1:0] strap_cnt;
        logic strap_done;
        logic slave;
        logic a0mux;
        logic [31:0] ctrl;
        logic [31:0] rdata;
        bcc_owner_type owner;
        logic ext_gnt;
        logic pci_gnt;
        logic ref_gnt;
        logic dma_gnt;
        logic cpu_gnt;
        logic addr_oe_n;
        logic strb_oe_n;
        logic [6:0] mux_sel;
        logic [5:0] len0;
        logic [5:0] len5;
        logic [5:0] len6;
    } bcc_state_type;

    bcc_state_type state_q;
    bcc_state_type state_d;

    // reserved burst codes fall back to plain SRAM access
    function automatic logic [5:0] burst_len(input logic [2:0] code);
        logic [5:0] len;
        len = BCC_LEN_NONE;
        unique case (code)
            BCC_BURST_4: len = BCC_LEN_4;
            BCC_BURST_8: len = BCC_LEN_8;
            BCC_BURST_16: len = BCC_LEN_16;
            BCC_BURST_32: len = BCC_LEN_32;
            default: len = BCC_LEN_NONE;
        endcase
        return len;
    endfunction

    // =========================================================
    // next state
    always_comb begin
        logic ext_ok;
        logic pci_ok;
        logic burst_hold;
        logic released;
        logic addr_float;
        logic strb_float;
        logic mux_field;
        logic [2:0] a0_code;
        logic [2:0] a5_code;
        logic [2:0] a6_code;
        bcc_owner_type win;
        ext_ok = 1'b0;
        pci_ok = 1'b0;
        burst_hold = 1'b0;
        released = 1'b0;
        addr_float = 1'b0;
        strb_float = 1'b0;
        mux_field = 1'b0;
        a0_code = BCC_BURST_SRAM;
        a5_code = BCC_BURST_SRAM;
        a6_code = BCC_BURST_SRAM;
        win = OWN_NONE;
        state_d = state_q;

        // synchronisers: first stage feeds only the second
        state_d.ext_req_s1 = ext_bus_req_pin;
        state_d.ext_req_s2 = state_q.ext_req_s1;
        state_d.slave_s1 = slave_mode_pin;
        state_d.slave_s2 = state_q.slave_s1;
        state_d.a0mux_s1 = area0_mux_pin;
        state_d.a0mux_s2 = state_q.a0mux_s1;

        // straps are caught once, after the sync chain has filled
        if (!state_q.strap_done) begin
            if (state_q.strap_cnt == BCC_STRAP_WAIT) begin
                state_d.strap_done = 1'b1;
                state_d.slave = state_q.slave_s2;
                state_d.a0mux = state_q.a0mux_s2;
            end else begin
                state_d.strap_cnt = state_q.strap_cnt + 2'h1;
            end
        end

        // register writes; reserved and read-only bits stay zero
        if (reg_wr && reg_addr == CTRL_ADDR) begin
            state_d.ctrl = reg_wdata & BCC_CTRL_WMASK;
        end

        // register reads, answered in the following cycle
        state_d.rdata = 32'h0000_0000;
        if (reg_rd) begin
            if (reg_addr == CTRL_ADDR) begin
                state_d.rdata = state_q.ctrl;
            end else if (reg_addr == STAT_ADDR) begin
                state_d.rdata[BCC_STAT_OWNER_LSB +: 3] = state_q.owner;
                state_d.rdata[BCC_STAT_SLAVE] = state_q.slave;
                state_d.rdata[BCC_STAT_A0MUX] = state_q.a0mux;
                state_d.rdata[BCC_STAT_STRAP_DONE] = state_q.strap_done;
            end
        end

        // request acceptance
        ext_ok = state_q.slave | state_q.ctrl[BCC_BIT_REQ_ACCEPT];
        pci_ok = state_q.slave | state_q.ctrl[BCC_BIT_REQ_ACCEPT];

        // a running DMA burst keeps the bus only under burst priority
        burst_hold = state_q.ctrl[BCC_BIT_DMA_PRIO] && state_q.owner == OWN_DMA
            && dma_burst_active && dma_req;

        // arbitration, re-evaluated every cycle
        if (burst_hold) begin
            win = OWN_DMA;
        end else if (state_q.ext_req_s2 && ext_ok) begin
            win = OWN_EXT;
        end else if (pci_bus_req && pci_ok) begin
            win = OWN_PCI;
        end else if (refresh_req) begin
            win = OWN_REFRESH;
        end else if (dma_req) begin
            win = OWN_DMA;
        end else if (cpu_req) begin
            win = OWN_CPU;
        end else begin
            win = OWN_NONE;
        end
        state_d.owner = win;
        state_d.ext_gnt = (win == OWN_EXT);
        state_d.pci_gnt = (win == OWN_PCI);
        state_d.ref_gnt = (win == OWN_REFRESH);
        state_d.dma_gnt = (win == OWN_DMA);
        state_d.cpu_gnt = (win == OWN_CPU);

        // pin float control; the address group always yields on release
        // because the new master owns the address lines then
        released = (win == OWN_EXT) || (win == OWN_PCI);
        addr_float = released || (standby && !state_q.ctrl[BCC_BIT_ADDR_FLOAT]);
        strb_float = (released || standby) && !state_q.ctrl[BCC_BIT_STRB_FLOAT];
        state_d.addr_oe_n = addr_float;
        state_d.strb_oe_n = strb_float;

        // access configuration is frozen at each access start so a write
        // never changes the interface in the middle of a bus cycle
        if (bus_access_start) begin
            mux_field = state_q.ctrl[BCC_BIT_MUX_SEL];
            a0_code = state_q.ctrl[BCC_A0_BURST_LSB +: BCC_BURST_W];
            a5_code = state_q.ctrl[BCC_A5_BURST_LSB +: BCC_BURST_W];
            a6_code = state_q.ctrl[BCC_A6_BURST_LSB +: BCC_BURST_W];
            state_d.mux_sel[0] = state_q.a0mux;
            state_d.mux_sel[4:1] = {4{mux_field}};
            // PC card use of areas 5 and 6 overrides mux and burst
            state_d.mux_sel[6:5] = {2{mux_field && !pc_card_sel}};
            if (state_q.a0mux) begin
                state_d.len0 = BCC_LEN_NONE;
            end else begin
                state_d.len0 = burst_len(a0_code);
            end
            if (mux_field || pc_card_sel) begin
                state_d.len5 = BCC_LEN_NONE;
            end else begin
                state_d.len5 = burst_len(a5_code);
            end
            if (mux_field || pc_card_sel) begin
                state_d.len6 = BCC_LEN_NONE;
            end else begin
                state_d.len6 = burst_len(a6_code);
            end
        end
    end

    // =========================================================
    // registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q.ext_req_s1 <= 1'b0;
            state_q.ext_req_s2 <= 1'b0;
            state_q.slave_s1 <= 1'b0;
            state_q.slave_s2 <= 1'b0;
            state_q.a0mux_s1 <= 1'b0;
            state_q.a0mux_s2 <= 1'b0;
            state_q.strap_cnt <= 2'h0;
            state_q.strap_done <= 1'b0;
            state_q.slave <= 1'b0;
            state_q.a0mux <= 1'b0;
            state_q.ctrl <= BCC_CTRL_RESET;
            state_q.rdata <= 32'h0000_0000;
            state_q.owner <= OWN_NONE;
            state_q.ext_gnt <= 1'b0;
            state_q.pci_gnt <= 1'b0;
            state_q.ref_gnt <= 1'b0;
            state_q.dma_gnt <= 1'b0;
            state_q.cpu_gnt <= 1'b0;
            state_q.addr_oe_n <= 1'b1;
            state_q.strb_oe_n <= 1'b1;
            state_q.mux_sel <= 7'h00;
            state_q.len0 <= BCC_LEN_NONE;
            state_q.len5 <= BCC_LEN_NONE;
            state_q.len6 <= BCC_LEN_NONE;
        end else begin
            state_q <= state_d;
        end
    end

    // =========================================================
    // outputs
    assign reg_rdata = state_q.rdata;
    assign ext_bus_grant = state_q.ext_gnt;
    assign pci_bus_grant = state_q.pci_gnt;
    assign refresh_grant = state_q.ref_gnt;
    assign dma_grant = state_q.dma_gnt;
    assign cpu_grant = state_q.cpu_gnt;
    assign addr_group_oe_n = state_q.addr_oe_n;
    assign strobe_group_oe_n = state_q.strb_oe_n;
    assign area_mux_sel = state_q.mux_sel;
    assign area_zero_burst_len = state_q.len0;
    assign area_five_burst_len = state_q.len5;
    assign area_six_burst_len = state_q.len6;
    assign slave_mode = state_q.slave;

endmodule : bcc_bus_control

`default_nettype wire

//--- verification/bcc_requester_model.sv
`default_nettype none

module bcc_requester_model (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic want,
    input wire logic grant,
    output logic req
);
    timeunit 1ns;
    timeprecision 1ns;
    int owned;
    // a real master hands the bus back by itself, so the request drops once four granted cycles have been counted
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            req <= 1'b0;
            owned <= 0;
        end else begin
            owned <= grant ? owned + 1 : 0;
            req <= want && owned < 4;
        end
    end
endmodule // bcc_requester_model

`default_nettype wire

//--- verification/bcc_bus_control_assertions.sv
`default_nettype none

module bcc_checker (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic pci_bus_req,
    input wire logic refresh_req,
    input wire logic dma_req,
    input wire logic cpu_req,
    input wire logic bus_access_start,
    input wire logic ext_bus_grant,
    input wire logic pci_bus_grant,
    input wire logic refresh_grant,
    input wire logic dma_grant,
    input wire logic cpu_grant,
    input wire logic [5:0] area_zero_burst_len,
    input wire logic [5:0] area_six_burst_len,
    input wire logic slave_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // =========================================================
    // arbitration
    grant_one_hot_a: assert property ($onehot0({ext_bus_grant, pci_bus_grant, refresh_grant,
        dma_grant, cpu_grant})) else $error("more than one grant");
    refresh_over_dma_a: assert property (refresh_req && dma_req && !dma_grant |=> !dma_grant)
        else $error("dma won over refresh");
    dma_over_cpu_a: assert property (cpu_req && dma_req |=> !cpu_grant)
        else $error("cpu won over dma");
    pci_needs_req_a: assert property (!pci_bus_req |=> !pci_bus_grant)
        else $error("pci grant without request");
    slave_pci_a: assert property (slave_mode && pci_bus_req && !dma_grant |=>
        pci_bus_grant || ext_bus_grant) else $error("pci refused in slave start");
    slave_sticky_a: assert property (slave_mode |=> slave_mode)
        else $error("slave mode lost");
    // =========================================================
    // access configuration
    area_hold_a: assert property (!bus_access_start |=>
        $stable(area_zero_burst_len) && $stable(area_six_burst_len))
        else $error("area config changed without access start");
    burst_len_legal_a: assert property (area_zero_burst_len inside {0, 4, 8, 16, 32} &&
        area_six_burst_len inside {0, 4, 8, 16, 32}) else $error("illegal burst length");
    cover property (pci_bus_grant && slave_mode);
    cover property (refresh_req && dma_grant);
    cover property (bus_access_start ##1 area_zero_burst_len == 6'h20);
endmodule // bcc_checker

bind bcc_bus_control bcc_checker u_chk (.ref_clk, .reset_n, .pci_bus_req, .refresh_req,
    .dma_req, .cpu_req, .bus_access_start, .ext_bus_grant, .pci_bus_grant, .refresh_grant,
    .dma_grant, .cpu_grant, .area_zero_burst_len, .area_six_burst_len, .slave_mode);

`default_nettype wire

//--- verification/bcc_bus_control_test.sv
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
    $display("CHECK FAILED t=%0t got %h want %h", $time, g, e); end end
`define WAIT(c) begin for (int k = 0; k < 40 && !(c); k++) step(); \
    if (!(c)) begin n_fail++; wrap_up(); end end

module bcc_bus_control_test import bcc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pc_card_sel = 1'b0;
    logic slave_mode_pin = 1'b0, area0_mux_pin = 1'b0, pci_bus_req = 1'b0, refresh_req = 1'b0;
    logic dma_req = 1'b0, dma_burst_active = 1'b0, cpu_req = 1'b0, standby = 1'b0;
    logic bus_access_start = 1'b0, ext_want = 1'b0, ext_bus_req_pin;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_val;
    logic ext_bus_grant, pci_bus_grant, refresh_grant, dma_grant, cpu_grant, slave_mode;
    logic addr_group_oe_n, strobe_group_oe_n;
    logic [6:0] area_mux_sel;
    logic [5:0] area_zero_burst_len, area_five_burst_len, area_six_burst_len;
    logic [15:0] seed = 16'h0063;
    logic [2:0] c0, c5, c6;
    logic [4:0] won;
    int n_fail = 0, checks_done = 0;
    wire logic [4:0] grants = {ext_bus_grant, pci_bus_grant, refresh_grant, dma_grant, cpu_grant};
    wire logic [17:0] lens = {area_zero_burst_len, area_five_burst_len, area_six_burst_len};
    wire logic [1:0] oe_n = {addr_group_oe_n, strobe_group_oe_n};

    bcc_bus_control #(.ADDR_W(8)) dut (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .slave_mode_pin, .area0_mux_pin, .pc_card_sel, .ext_bus_req_pin,
        .pci_bus_req, .refresh_req, .dma_req, .dma_burst_active, .cpu_req, .standby,
        .bus_access_start, .ext_bus_grant, .pci_bus_grant, .refresh_grant, .dma_grant,
        .cpu_grant, .addr_group_oe_n, .strobe_group_oe_n, .area_mux_sel, .area_zero_burst_len,
        .area_five_burst_len, .area_six_burst_len, .slave_mode);
    bcc_requester_model ext_master (.ref_clk, .reset_n, .want(ext_want),
        .grant(ext_bus_grant), .req(ext_bus_req_pin));

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end

    // =========================================================
    // helpers
    function automatic logic [5:0] exp_len(input logic [2:0] c);
        case (c)
            3'h1: return 6'h04;
            3'h2: return 6'h08;
            3'h3: return 6'h10;
            3'h4: return 6'h20;
            default: return 6'h00;
        endcase
    endfunction
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= BCC_CTRL_OFS;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    task automatic start_access();
        @(posedge ref_clk);
        bus_access_start <= 1'b1;
        @(posedge ref_clk);
        bus_access_start <= 1'b0;
        #1;
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // =========================================================
    // main sequence
    initial begin
        cyc(8);
        reset_n <= 1'b1;
        cyc(4);
        rd(BCC_CTRL_OFS);
        `CHK(rd_val, 32'h0)
        wr(32'hFFFF_FFFF);
        rd(BCC_CTRL_OFS);
        `CHK(rd_val, 32'h000B_FFE0)
        rd(8'h08);
        `CHK(rd_val, 32'h0)
        @(posedge ref_clk);
        standby <= 1'b1;
        cyc(2);
        step();
        `CHK(oe_n, 2'b00)
        foreach (c0[i]) begin
            wr(i == 0 ? 32'h0000_8000 : 32'h0);
            cyc(1);
            step();
            `CHK(oe_n, i == 0 ? 2'b01 : 2'b11)
        end
        @(posedge ref_clk);
        standby <= 1'b0;
        pci_bus_req <= 1'b1;
        cyc(3);
        step();
        `CHK(grants, 5'h00)
        wr(32'h0008_0000);
        `WAIT(pci_bus_grant)
        cyc(1);
        step();
        `CHK(oe_n, 2'b11)
        // every requester asks at once; dropping the winner exposes the next in line
        @(posedge ref_clk);
        {ext_want, refresh_req, dma_req, cpu_req} <= 4'hF;
        for (int i = 0; i < 5; i++) begin
            `WAIT(grants == (5'h10 >> i))
            `CHK(grants, 5'h10 >> i)
            won = grants;
            @(posedge ref_clk);
            {ext_want, pci_bus_req, refresh_req, dma_req, cpu_req} <= won ^ {ext_want,
                pci_bus_req, refresh_req, dma_req, cpu_req};
        end
        wr(32'h0009_0000);
        {dma_req, dma_burst_active} <= 2'b11;
        `WAIT(dma_grant)
        @(posedge ref_clk);
        {ext_want, refresh_req} <= 2'b11;
        cyc(5);
        step();
        `CHK(grants, 5'h02)
        @(posedge ref_clk);
        dma_burst_active <= 1'b0;
        `WAIT(ext_bus_grant)
        `CHK(grants, 5'h10)
        @(posedge ref_clk);
        {ext_want, refresh_req, dma_req} <= 3'h0;
        for (int i = 0; i < 14; i++) begin
            seed = lfsr(seed);
            {c0, c5, c6} = i == 0 ? 9'o444 : (i == 1 ? 9'o777 : seed[8:0]);
            wr({18'h0, c0, c5, c6, 5'h00});
            start_access();
            `CHK(lens, {exp_len(c0), exp_len(c5), exp_len(c6)})
        end
        foreach (c0[i]) begin
            wr(i == 0 ? 32'h0002_2480 : 32'h0);
            start_access();
            `CHK(area_mux_sel[6:1], i == 0 ? 6'h3F : 6'h00)
            `CHK(lens, i == 0 ? 18'h20000 : 18'h0)
        end
        // pc card use of areas 5 and 6: software leaves the area 5 field at zero
        @(posedge ref_clk);
        pc_card_sel <= 1'b1;
        wr(32'h0002_2080);
        start_access();
        `CHK(area_mux_sel, 7'h1E)
        `CHK(lens, 18'h20000)
        @(posedge ref_clk);
        {reset_n, slave_mode_pin, area0_mux_pin} <= 3'b011;
        cyc(8);
        reset_n <= 1'b1;
        cyc(5);
        wr(32'h0000_2000);
        start_access();
        `CHK({slave_mode, area_mux_sel[0]}, 2'b11)
        `CHK(area_zero_burst_len, 6'h00)
        rd(BCC_CTRL_OFS);
        `CHK(rd_val, 32'h0000_2000)
        @(posedge ref_clk);
        pci_bus_req <= 1'b1;
        `WAIT(pci_bus_grant)
        `CHK(grants, 5'h08)
        wrap_up();
    end
endmodule // bcc_bus_control_test

`default_nettype wire
